// file: anps_pkg.sv
// Package with offsets, field positions and reset values of the partner next-page status block.
package anps_pkg;

   // Management register offsets inside the negotiation device.
   localparam logic [15:0] ANPS_OFS_PAGE_LOW  = 16'h0019;
   localparam logic [15:0] ANPS_OFS_PAGE_MID  = 16'h001A;
   localparam logic [15:0] ANPS_OFS_PAGE_HIGH = 16'h001B;
   localparam logic [15:0] ANPS_OFS_STATUS    = 16'h0030;

   // Reset values of the four registers.
   localparam logic [15:0] ANPS_RST_PAGE_LOW  = 16'h0000;
   localparam logic [15:0] ANPS_RST_PAGE_MID  = 16'h0000;
   localparam logic [15:0] ANPS_RST_PAGE_HIGH = 16'h0000;
   localparam logic [15:0] ANPS_RST_STATUS    = 16'h0001;

   // Field positions of the low page word.
   localparam int ANPS_BIT_MORE_PAGES   = 15;
   localparam int ANPS_BIT_PAGE_ACK     = 14;
   localparam int ANPS_BIT_MESSAGE_PAGE = 13;
   localparam int ANPS_BIT_CAN_COMPLY   = 12;
   localparam int ANPS_BIT_TOGGLE       = 11;
   localparam int ANPS_CODE_MSB         = 10;
   localparam int ANPS_CODE_LSB         = 0;

   // Field positions of the status register.
   localparam int ANPS_BIT_FAST_FEC = 4;
   localparam int ANPS_BIT_FAST     = 3;
   localparam int ANPS_BIT_SLOW     = 1;
   localparam int ANPS_BIT_PRESENT  = 0;

   // Widths of the received page, of the read snapshot and of one management word.
   localparam int ANPS_PAGE_W = 48;
   localparam int ANPS_WORD_W = 16;
   localparam int ANPS_SNAP_W = 32;

   // Whole state of the block, registered as one word.
   typedef struct packed {
      logic [ANPS_PAGE_W-1:0] page;
      logic [ANPS_SNAP_W-1:0] snap;
      logic                   fast_fec;
      logic                   fast;
      logic                   slow;
      logic [ANPS_WORD_W-1:0] rdata;
      logic                   rvalid;
   } anps_state_t;

endpackage

// file: anps_partner_page.sv
// Partner next-page and negotiation status registers, read over the management port.
//
// Overview of operation
// - Low word bit 15 shows partner more-pages.
// - Low word bit 14 shows partner acknowledge.
// - Bit 13 shows message-page flag, resets zero.
// - Bit 12 shows partner second acknowledge.
// - Bit 11 shows partner toggle, resets zero.
// - Bits 10 to 0 hold partner code.
// - Mid word shows page positions 31 to 16 as frozen by the last low word read.
// - High word shows page positions 47 to 32 as frozen by the last low word read.
// - Status bit 4 shows fast link FEC.
// - Status bit 3 shows fast backplane link.
// - Status bit 1 shows slow backplane link.
// - Status bit 0 always one, resets 0x0001.
// - Page words read-only, reset zero, ignore writes.
`timescale 1ns/1ps
module anps_partner_page (
   input  wire logic                            mclk,
   input  wire logic                            resetn,
   input  wire logic                            rx_page_valid,
   input  wire logic [anps_pkg::ANPS_PAGE_W-1:0] rx_page_data,
   input  wire logic                            resolved_fast_link_fec,
   input  wire logic                            resolved_fast_link,
   input  wire logic                            resolved_slow_link,
   input  wire logic                            mgmt_rd,
   input  wire logic                            mgmt_wr,
   input  wire logic [anps_pkg::ANPS_WORD_W-1:0] mgmt_addr,
   input  wire logic [anps_pkg::ANPS_WORD_W-1:0] mgmt_wdata,
   output logic      [anps_pkg::ANPS_WORD_W-1:0] mgmt_rdata,
   output logic                                 mgmt_rvalid
);
   import anps_pkg::*;

   logic [1:0]  rst_sync_q;
   logic        rst_n;
   anps_state_t st_q;
   anps_state_t st_d;
   logic        rd_low;
   logic        rd_mid;
   logic        rd_high;
   logic        rd_status;
   logic        wdata_unused;

   // Reset is asserted at once and released through two flip-flops.
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         rst_sync_q <= 2'h0;
      end else begin
         rst_sync_q <= {rst_sync_q[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_q[1];

   // Address decode of the management read strobes.
   assign rd_low    = mgmt_rd && (mgmt_addr == ANPS_OFS_PAGE_LOW);
   assign rd_mid    = mgmt_rd && (mgmt_addr == ANPS_OFS_PAGE_MID);
   assign rd_high   = mgmt_rd && (mgmt_addr == ANPS_OFS_PAGE_HIGH);
   assign rd_status = mgmt_rd && (mgmt_addr == ANPS_OFS_STATUS);

   // Every register here is read-only, so write data is deliberately discarded.
   assign wdata_unused = mgmt_wr ^ (^mgmt_wdata);

   // Next state: page capture, read snapshot and read answer.
   always_comb begin
      st_d        = st_q;
      st_d.rvalid = mgmt_rd;
      // A newly accepted partner page replaces all 48 bits at once.
      if (rx_page_valid) begin
         st_d.page = rx_page_data;
      end
      // Resolved link type follows the receive side of negotiation.
      st_d.fast_fec = resolved_fast_link_fec;
      st_d.fast     = resolved_fast_link;
      st_d.slow     = resolved_slow_link;
      // Reading the low word freezes the upper words of that same page.
      if (rd_low) begin
         st_d.snap = st_q.page[ANPS_PAGE_W-1:ANPS_WORD_W];
      end
      if (mgmt_rd) begin
         st_d.rdata = '0;
         if (rd_low) begin
            st_d.rdata[ANPS_BIT_MORE_PAGES]   = st_q.page[ANPS_BIT_MORE_PAGES];
            st_d.rdata[ANPS_BIT_PAGE_ACK]     = st_q.page[ANPS_BIT_PAGE_ACK];
            st_d.rdata[ANPS_BIT_MESSAGE_PAGE] = st_q.page[ANPS_BIT_MESSAGE_PAGE];
            st_d.rdata[ANPS_BIT_CAN_COMPLY]   = st_q.page[ANPS_BIT_CAN_COMPLY];
            st_d.rdata[ANPS_BIT_TOGGLE]       = st_q.page[ANPS_BIT_TOGGLE];
            st_d.rdata[ANPS_CODE_MSB:ANPS_CODE_LSB] = st_q.page[ANPS_CODE_MSB:ANPS_CODE_LSB];
         end else if (rd_mid) begin
            st_d.rdata = st_q.snap[ANPS_WORD_W-1:0];
         end else if (rd_high) begin
            st_d.rdata = st_q.snap[ANPS_SNAP_W-1:ANPS_WORD_W];
         end else if (rd_status) begin
            st_d.rdata[ANPS_BIT_FAST_FEC] = st_q.fast_fec;
            st_d.rdata[ANPS_BIT_FAST]     = st_q.fast;
            st_d.rdata[ANPS_BIT_SLOW]     = st_q.slow;
            st_d.rdata[ANPS_BIT_PRESENT]  = 1'b1;
         end
      end
   end

   // State register; page words and snapshot clear to zero on reset.
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         st_q.page     <= {ANPS_RST_PAGE_HIGH, ANPS_RST_PAGE_MID, ANPS_RST_PAGE_LOW};
         st_q.snap     <= {ANPS_RST_PAGE_HIGH, ANPS_RST_PAGE_MID};
         st_q.fast_fec <= ANPS_RST_STATUS[ANPS_BIT_FAST_FEC];
         st_q.fast     <= ANPS_RST_STATUS[ANPS_BIT_FAST];
         st_q.slow     <= ANPS_RST_STATUS[ANPS_BIT_SLOW];
         st_q.rdata    <= '0;
         st_q.rvalid   <= 1'b0;
      end else begin
         st_q <= st_d;
      end
   end

   // Read answer comes straight from the state register.
   assign mgmt_rdata  = st_q.rdata;
   assign mgmt_rvalid = st_q.rvalid;

   // Checks of the register behaviour against its causes.
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);

   sequence s_low_then_mid;
      rd_low ##1 rd_mid;
   endsequence

   sequence s_low_then_high;
      rd_low ##1 rd_high;
   endsequence

   a_page_load_all: assert property (rx_page_valid |=> st_q.page == $past(rx_page_data))
      else $error("Accepted partner page was not loaded.");

   a_more_pages_bit: assert property (rx_page_valid ##1 rd_low |=> mgmt_rdata[15] == $past(rx_page_data[15], 2))
      else $error("More-pages bit differs from received page.");

   a_page_ack_bit: assert property (rd_low |=> mgmt_rvalid && mgmt_rdata[14] == $past(st_q.page[14]))
      else $error("Acknowledge bit differs from stored page.");

   a_message_page_bit: assert property (rd_low |=> mgmt_rdata[13] == $past(st_q.page[13]))
      else $error("Message-page bit differs from stored page.");

   a_comply_bit: assert property (rx_page_valid ##1 rd_low |=> mgmt_rdata[12] == $past(rx_page_data[12], 2))
      else $error("Second acknowledge bit differs from received page.");

   a_toggle_bit: assert property (rd_low |=> mgmt_rdata[11] == $past(st_q.page[11]))
      else $error("Toggle bit differs from stored page.");

   a_code_field: assert property (rd_low |=> mgmt_rdata[10:0] == $past(st_q.page[10:0]))
      else $error("Code field differs from stored page.");

   a_mid_word_read: assert property (s_low_then_mid |=> mgmt_rdata == $past(st_q.page[31:16], 2))
      else $error("Mid word is not bits 31 to 16 of the page.");

   a_high_word_read: assert property (s_low_then_high |=> mgmt_rdata == $past(st_q.page[47:32], 2))
      else $error("High word is not bits 47 to 32 of the page.");

   a_snapshot_hold: assert property (!rd_low |=> st_q.snap == $past(st_q.snap))
      else $error("Snapshot changed without a low word read.");

   a_fec_status: assert property (resolved_fast_link_fec ##1 rd_status |=> mgmt_rdata[4])
      else $error("FEC status bit did not follow resolution.");

   a_fast_status: assert property (rd_status |=> mgmt_rdata[3] == $past(st_q.fast))
      else $error("Fast link status bit wrong.");

   a_slow_status: assert property (!resolved_slow_link ##1 rd_status |=> !mgmt_rdata[1])
      else $error("Slow link status bit wrong.");

   a_present_bit: assert property (rd_status |=> mgmt_rdata[0] && mgmt_rdata[15:5] == 11'h000)
      else $error("Status register fixed bits wrong.");

   a_write_ignored: assert property (mgmt_wr && !rx_page_valid |=> $stable(st_q.page))
      else $error("Management write changed a page word.");

   // Further checks of the snapshot path, the status bits and the page hold.
   sequence s_load_then_low;
      rx_page_valid ##1 rd_low;
   endsequence

   sequence s_page_walk;
      rd_low ##1 rd_mid ##1 rd_high;
   endsequence

   a_snap_capture: assert property (rd_low |=> st_q.snap == $past(st_q.page[47:16]))
      else $error("Low word read did not capture the upper page bits.");

   a_mid_from_snap: assert property (rd_mid |=> mgmt_rdata == $past(st_q.snap[15:0]))
      else $error("Mid word read did not return the lower snapshot half.");

   a_high_from_snap: assert property (rd_high |=> mgmt_rdata == $past(st_q.snap[31:16]))
      else $error("High word read did not return the upper snapshot half.");

   a_page_walk: assert property (s_page_walk |=> mgmt_rdata == $past(st_q.page[47:32], 3))
      else $error("High word after a full walk differs from the page read first.");

   a_ack_new: assert property (s_load_then_low |=> mgmt_rdata[14] == $past(rx_page_data[14], 2))
      else $error("Acknowledge bit differs from received page.");

   a_message_new: assert property (s_load_then_low |=> mgmt_rdata[13] == $past(rx_page_data[13], 2))
      else $error("Message-page bit differs from received page.");

   a_toggle_new: assert property (s_load_then_low |=> mgmt_rdata[11] == $past(rx_page_data[11], 2))
      else $error("Toggle bit differs from received page.");

   a_code_new: assert property (s_load_then_low |=> mgmt_rdata[10:0] == $past(rx_page_data[10:0], 2))
      else $error("Code field differs from received page.");

   a_fec_clear: assert property (!resolved_fast_link_fec ##1 rd_status |=> !mgmt_rdata[4])
      else $error("FEC status bit set without resolution.");

   a_fast_follow: assert property (resolved_fast_link ##1 rd_status |=> mgmt_rdata[3])
      else $error("Fast link status bit did not follow resolution.");

   a_slow_set: assert property (resolved_slow_link ##1 rd_status |=> mgmt_rdata[1])
      else $error("Slow link status bit did not follow resolution.");

   a_page_stable: assert property (!rx_page_valid |=> $stable(st_q.page))
      else $error("Stored page changed without an accepted page.");

   a_write_no_snap: assert property (mgmt_wr && !rd_low |=> $stable(st_q.snap))
      else $error("Management write changed the snapshot.");

endmodule

// file: anps_link_partner.sv
// Behavioural remote link partner that hands accepted next pages to the block.
`timescale 1ns/1ps
module anps_link_partner (
   input  wire logic                            mclk,
   output logic                                 rx_page_valid,
   output logic [anps_pkg::ANPS_PAGE_W-1:0]     rx_page_data
);
   // Starts idle with no page offered.
   initial begin
      rx_page_valid = 1'b0;
      rx_page_data  = '0;
   end
   // Offers one whole page for one cycle, then leaves the inverse on the idle lines.
   task automatic send(input logic [anps_pkg::ANPS_PAGE_W-1:0] page);
      @(negedge mclk);
      rx_page_valid = 1'b1;
      rx_page_data  = page;
      @(negedge mclk);
      rx_page_valid = 1'b0;
      rx_page_data  = ~page;
   endtask
endmodule

// file: autoneg_partner_next_page_status_test.sv
// Self-checking bench for the partner next-page and negotiation status registers.
`timescale 1ns/1ps
module autoneg_partner_next_page_status_test;
   import anps_pkg::*;
   typedef struct packed { logic [15:0] addr; logic [2:0] st; logic [15:0] exp; } anps_row_t;
   localparam logic [47:0] P1 = 48'hC3A5_5A3C_A955;
   localparam logic [47:0] P2 = 48'h3C5A_A5C3_56AA;
   logic        mclk, resetn, rd, wr, fec, fast, slow, vld, rvalid;
   logic [47:0] pdata;
   logic [15:0] addr, wdata, rdata;
   int          bad_count, compares;
   // Low word first, then the snapshot words, then status codes and a hole in the map.
   anps_row_t rows [8] = '{
      '{ANPS_OFS_PAGE_LOW, 3'b000, 16'hA955}, '{ANPS_OFS_PAGE_MID, 3'b000, 16'h5A3C},
      '{ANPS_OFS_PAGE_HIGH, 3'b000, 16'hC3A5}, '{ANPS_OFS_STATUS, 3'b100, 16'h0011},
      '{ANPS_OFS_STATUS, 3'b010, 16'h0009}, '{ANPS_OFS_STATUS, 3'b001, 16'h0003},
      '{ANPS_OFS_STATUS, 3'b111, 16'h001B}, '{16'h0040, 3'b000, 16'h0000}};
   anps_partner_page dut (.mclk(mclk), .resetn(resetn), .rx_page_valid(vld), .rx_page_data(pdata),
      .resolved_fast_link_fec(fec), .resolved_fast_link(fast), .resolved_slow_link(slow),
      .mgmt_rd(rd), .mgmt_wr(wr), .mgmt_addr(addr), .mgmt_wdata(wdata), .mgmt_rdata(rdata),
      .mgmt_rvalid(rvalid));
   anps_link_partner partner (.mclk(mclk), .rx_page_valid(vld), .rx_page_data(pdata));
   // Free-running core clock.
   always #50 mclk = ~mclk;
   // Prints the counts and the verdict, then ends the run.
   task automatic wrap_up;
      $display("compares %0d bad_count %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   // Counts one comparison of valid flag and read data, and reports a mismatch.
   task automatic check(input logic [16:0] got, input logic [16:0] exp);
      compares++;
      if (got !== exp) begin
         bad_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // One read strobe, checked while the one-cycle answer stands.
   task automatic rd_chk(input logic [15:0] a, input logic [15:0] exp);
      @(negedge mclk);
      rd = 1'b1;
      addr = a;
      @(negedge mclk);
      rd = 1'b0;
      check({rvalid, rdata}, {1'b1, exp});
   endtask
   // Three reads back to back from the current falling edge; each answer is checked as the next strobe is set up.
   task automatic rd_burst3(input logic [15:0] a0, e0, a1, e1, a2, e2);
      rd = 1'b1;
      addr = a0;
      @(negedge mclk);
      addr = a1;
      check({rvalid, rdata}, {1'b1, e0});
      @(negedge mclk);
      addr = a2;
      check({rvalid, rdata}, {1'b1, e1});
      @(negedge mclk);
      rd = 1'b0;
      check({rvalid, rdata}, {1'b1, e2});
   endtask
   // Releases reset and checks every register's value after reset.
   task automatic reset_chk;
      repeat (2) @(negedge mclk);
      check({rvalid, rdata}, 17'h00000); // Answer cleared while in reset.
      resetn = 1'b1;
      repeat (3) @(posedge mclk);
      rd_chk(ANPS_OFS_PAGE_LOW, 16'h0000); // Low word clear.
      rd_chk(ANPS_OFS_PAGE_MID, 16'h0000); // Mid word clear.
      rd_chk(ANPS_OFS_PAGE_HIGH, 16'h0000); // High word clear.
      rd_chk(ANPS_OFS_STATUS, 16'h0001); // Status default.
   endtask
   // Main sequence: reset, table rows, then the awkward cases.
   initial begin
      mclk = 1'b0; resetn = 1'b0; rd = 1'b0; wr = 1'b0; addr = '0; wdata = '0;
      fec = 1'b0; fast = 1'b0; slow = 1'b0; bad_count = 0; compares = 0;
      reset_chk();
      partner.send(P1);
      foreach (rows[i]) begin
         {fec, fast, slow} = rows[i].st;
         rd_chk(rows[i].addr, rows[i].exp); // Rows in turn.
      end
      @(negedge mclk);
      wr = 1'b1;
      addr = ANPS_OFS_PAGE_LOW;
      wdata = 16'hFFFF;
      @(negedge mclk);
      wr = 1'b0;
      rd_chk(ANPS_OFS_PAGE_LOW, 16'hA955); // Write had no effect.
      partner.send(P2);
      rd_chk(ANPS_OFS_PAGE_MID, 16'h5A3C); // Old snapshot kept.
      rd_chk(ANPS_OFS_PAGE_HIGH, 16'hC3A5); // Old snapshot kept.
      rd_chk(ANPS_OFS_PAGE_LOW, 16'h56AA); // New page fields.
      rd_chk(ANPS_OFS_PAGE_MID, 16'hA5C3); // New snapshot.
      rd_chk(ANPS_OFS_PAGE_HIGH, 16'h3C5A); // New snapshot.
      // Page followed at once by back-to-back reads, in both orders of the upper words.
      partner.send(P1);
      rd_burst3(ANPS_OFS_PAGE_LOW, 16'hA955, ANPS_OFS_PAGE_MID, 16'h5A3C,
                ANPS_OFS_PAGE_HIGH, 16'hC3A5);
      partner.send(P2);
      rd_burst3(ANPS_OFS_PAGE_LOW, 16'h56AA, ANPS_OFS_PAGE_HIGH, 16'h3C5A,
                ANPS_OFS_PAGE_MID, 16'hA5C3);
      fast = 1'b1;
      @(negedge mclk);
      resetn = 1'b0;
      fast = 1'b0;
      reset_chk();
      wrap_up();
   end
   // Watchdog well beyond the expected run length.
   initial begin
      #200000;
      bad_count++;
      wrap_up();
   end
endmodule
